//--- inc/dma_ram_pkg.sv
// Purpose: constants shared by the dual-ported DMA RAM block
// Assumes: 16-bit byte-addressed data space, one system clock
// Notes:   default base puts the array at the top of an 8 KB data space
//
// Functional notes
// RULE1: 2 KB two-port array at data space top
// RULE2: both ports served in the same cycle
// RULE3: DMA accesses never take CPU cycles
// RULE4: same-word same-cycle writes: CPU data wins
// RULE5: CPU port never sees a wait
// RULE6: DMA reads and writes any array location
// RULE7: array usable as plain CPU storage
// RULE8: byte write touches only addressed lane
// RULE9: byte read returns selected byte low
// RULE10: reads outside the array return zero
// RULE11: base decode, 2 KB window, one-cycle reads
package dma_ram_pkg;
    localparam int          ADDR_W      = 16;
    localparam int          DATA_W      = 16;
    localparam int          WORDS       = 1024;
    localparam int          IDX_W       = 10;
    localparam logic [15:0] BASE_DFLT   = 16'h1800;
    localparam logic [15:0] WIN_MASK    = 16'hf800;
    localparam int          BYTE_SEL    = 0;
    localparam logic [15:0] DATA_RST    = 16'h0000;
    localparam int          LANES       = 2;
    localparam int          LANE_W      = 8;
    localparam logic [1:0]  LANE_LO     = 2'h1;
    localparam logic [1:0]  LANE_HI     = 2'h2;
    localparam logic [1:0]  LANE_BOTH   = 2'h3;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
endpackage

//--- verilog/dma_ram_port.sv
// Purpose: address decode and byte-lane steering for one RAM port
// Assumes: word accesses are even-aligned by the requester
// Notes:   purely combinational
`timescale 1ns/1ps
module dma_ram_port
    import dma_ram_pkg::*;
#(
    parameter logic [15:0] BASE = BASE_DFLT
) (
    // request
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              byte_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    // decoded
    output logic                   hit_o,
    output logic [IDX_W-1:0]       idx_o,
    output logic [1:0]             lane_o,
    output logic [DATA_W-1:0]      wpos_o
);
    always_comb begin
        hit_o  = ((addr_i & WIN_MASK) == BASE); // RULE11
        idx_o  = addr_i[IDX_W:1];
        if (byte_i) begin
            // low byte of the data path goes to the addressed lane
            lane_o = addr_i[BYTE_SEL] ? LANE_HI : LANE_LO; // RULE8
            wpos_o = {wdata_i[LANE_W-1:0], wdata_i[LANE_W-1:0]};
        end else begin
            lane_o = LANE_BOTH;
            wpos_o = wdata_i;
        end
    end
endmodule

//--- verilog/dma_ram.sv
// Purpose: 2 KB dual-ported RAM shared by CPU and DMA controller
// Assumes: single clock, requests are single-cycle strobes
// Notes:   no ready/wait signal exists; both ports always complete
//          every access in the cycle it is taken
//          a clash on one byte lane keeps the cpu byte only; the
//          other lane of a dma word write still lands
//          misaligned word accesses ignore address bit 0; no trap
//          is raised here, that belongs to the requester
//          BASE must be 2 KB aligned or the window decode breaks
//          the array resets to zero; reads outside the window give
//          zero with a normal valid pulse
`timescale 1ns/1ps
module dma_ram
    import dma_ram_pkg::*;
#(
    parameter logic [15:0] BASE = BASE_DFLT
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // cpu port
    input  wire logic              cpu_req_i,
    input  wire logic              cpu_we_i,
    input  wire logic              cpu_byte_i,
    input  wire logic [ADDR_W-1:0] cpu_addr_i,
    input  wire logic [DATA_W-1:0] cpu_wdata_i,
    output logic      [DATA_W-1:0] cpu_rdata_o,
    output logic                   cpu_rvalid_o,
    // dma port
    input  wire logic              dma_req_i,
    input  wire logic              dma_we_i,
    input  wire logic              dma_byte_i,
    input  wire logic [ADDR_W-1:0] dma_addr_i,
    input  wire logic [DATA_W-1:0] dma_wdata_i,
    output logic      [DATA_W-1:0] dma_rdata_o,
    output logic                   dma_rvalid_o
);
    // storage: one word of flip-flops per entry, two byte lanes each
    logic [DATA_W-1:0] mem_q [WORDS]; // RULE1
    // per-port decode results
    logic              c_hit;
    logic              d_hit;
    logic [IDX_W-1:0]  c_idx;
    logic [IDX_W-1:0]  d_idx;
    logic [1:0]        c_lane;
    logic [1:0]        d_lane;
    logic [DATA_W-1:0] c_wpos;
    logic [DATA_W-1:0] d_wpos;

    // the two ports share nothing but the array, so neither can
    // hold the other off; this is what keeps the cpu free of stalls
    dma_ram_port #(.BASE(BASE)) u_cpu (
        // request
        .addr_i  (cpu_addr_i),
        .byte_i  (cpu_byte_i),
        .wdata_i (cpu_wdata_i),
        // decoded
        .hit_o   (c_hit),
        .idx_o   (c_idx),
        .lane_o  (c_lane),
        .wpos_o  (c_wpos)
    );
    dma_ram_port #(.BASE(BASE)) u_dma (
        // request
        .addr_i  (dma_addr_i),
        .byte_i  (dma_byte_i),
        .wdata_i (dma_wdata_i),
        // decoded
        .hit_o   (d_hit),
        .idx_o   (d_idx),
        .lane_o  (d_lane),
        .wpos_o  (d_wpos)
    );

    // request qualification
    logic c_wr;
    logic d_wr;
    logic c_rd;
    logic d_rd;

    // a write outside the window is dropped here; a read outside the
    // window still answers, with zero data, so the requester never waits
    assign c_wr = cpu_req_i & cpu_we_i & c_hit;
    assign d_wr = dma_req_i & dma_we_i & d_hit; // RULE6
    // reads are not qualified by the window: the miss is handled
    // when the read data is chosen
    assign c_rd = cpu_req_i & ~cpu_we_i;
    assign d_rd = dma_req_i & ~dma_we_i;

    // lane strobes of each port, before the collision check
    logic [LANES-1:0] c_lane_we;
    logic [LANES-1:0] d_lane_we;
    // lanes that both ports write at the same word in one cycle
    logic             same_word;
    logic [LANES-1:0] clash;
    // dma lanes that survive the collision check
    logic [LANES-1:0] d_lane_keep;

    assign same_word = (c_idx == d_idx);

    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_strobe
            assign c_lane_we[gl] = c_wr & c_lane[gl];
            assign d_lane_we[gl] = d_wr & d_lane[gl];
            assign clash[gl] = c_lane_we[gl] & d_lane_we[gl] & same_word;
            // only the colliding lane of a dma word write is lost
            assign d_lane_keep[gl] = d_lane_we[gl] & ~clash[gl]; // RULE4
        end
    endgenerate

    // the array costs one flop per bit; a memory macro would need two
    // true write ports plus the same lane priority, so flops were kept
    // for a 2 KB array

    // each word and lane has its own write port, so both sides commit
    // in one cycle; the cpu branch comes first as well, so a clash that
    // slipped past the strobes would still resolve the same way
    genvar gw, gb;
    generate
        for (gw = 0; gw < WORDS; gw++) begin : g_word
            for (gb = 0; gb < LANES; gb++) begin : g_lane
                logic c_sel;
                logic d_sel;
                assign c_sel = c_lane_we[gb] && (c_idx == IDX_W'(gw));
                assign d_sel = d_lane_keep[gb] && (d_idx == IDX_W'(gw));
                always_ff @(posedge clk_i or posedge sys_rst_i) begin
                    if (sys_rst_i) begin
                        mem_q[gw][gb*LANE_W +: LANE_W] <=
                            DATA_RST[gb*LANE_W +: LANE_W];
                    end else if (c_sel) begin
                        mem_q[gw][gb*LANE_W +: LANE_W] <=
                            c_wpos[gb*LANE_W +: LANE_W]; // RULE4
                    end else if (d_sel) begin
                        mem_q[gw][gb*LANE_W +: LANE_W] <=
                            d_wpos[gb*LANE_W +: LANE_W]; // RULE2
                    end
                end
            end
        end
    endgenerate

    // byte select of a read: the addressed lane lands in the low byte
    // and the upper byte is filled with zeros
    function automatic logic [DATA_W-1:0] lane_pick(
        input logic [DATA_W-1:0] word,
        input logic              odd
    );
        logic [LANE_W-1:0] b;
        b = odd ? word[DATA_W-1:LANE_W] : word[LANE_W-1:0];
        return {BYTE_ZERO, b}; // RULE9
    endfunction

    // read result of one port; outside the window the word is zero
    function automatic logic [DATA_W-1:0] pick(
        input logic [DATA_W-1:0] word,
        input logic              hit,
        input logic              is_byte,
        input logic              odd
    );
        logic [DATA_W-1:0] r;
        r = DATA_RST; // RULE10
        if (hit) begin
            if (is_byte) begin
                r = lane_pick(word, odd); // RULE9
            end else begin
                r = word;
            end
        end
        return r;
    endfunction

    // next read data, taken from the array as it stands before the
    // edge: a read that meets a write to the same word sees the old word
    logic [DATA_W-1:0] c_rdata_d;
    logic [DATA_W-1:0] d_rdata_d;

    always_comb begin
        c_rdata_d = pick(mem_q[c_idx], c_hit, cpu_byte_i,
                         cpu_addr_i[BYTE_SEL]); // RULE3
        d_rdata_d = pick(mem_q[d_idx], d_hit, dma_byte_i,
                         dma_addr_i[BYTE_SEL]); // RULE6
    end

    // answer timing: a read taken on one edge shows its valid pulse and
    // its data right after that edge; the pulse lasts one cycle and the
    // data then holds until the next read on the same port

    // cpu answer strobe: one pulse per read, whatever the dma port does
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_rvalid_o <= 1'b0;
        end else begin
            cpu_rvalid_o <= c_rd; // RULE5
        end
    end

    // cpu read data holds until the next cpu read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cpu_rdata_o <= DATA_RST;
        end else if (c_rd) begin
            cpu_rdata_o <= c_rdata_d; // RULE11
        end
    end

    // dma answer strobe, independent of the cpu port
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dma_rvalid_o <= 1'b0;
        end else begin
            dma_rvalid_o <= d_rd; // RULE11
        end
    end

    // dma read data holds until the next dma read
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dma_rdata_o <= DATA_RST;
        end else if (d_rd) begin
            dma_rdata_o <= d_rdata_d; // RULE6
        end
    end
endmodule

//--- verif/dma_ram_monitor.sv
// Purpose: port checks for dma_ram
// Assumes: one clock, reset active high
// Notes:   bound from the bench top
`timescale 1ns/1ps
module dma_ram_monitor
    import dma_ram_pkg::*;
#(
    parameter logic [15:0] BASE = BASE_DFLT
) (
    // clock and reset
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    // cpu port
    input wire logic              cpu_req_i,
    input wire logic              cpu_we_i,
    input wire logic              cpu_byte_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic [DATA_W-1:0] cpu_wdata_i,
    input wire logic [DATA_W-1:0] cpu_rdata_o,
    input wire logic              cpu_rvalid_o,
    // dma port
    input wire logic              dma_req_i,
    input wire logic              dma_we_i,
    input wire logic              dma_byte_i,
    input wire logic [ADDR_W-1:0] dma_addr_i,
    input wire logic [DATA_W-1:0] dma_wdata_i,
    input wire logic [DATA_W-1:0] dma_rdata_o,
    input wire logic              dma_rvalid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_crd; cpu_req_i && !cpu_we_i; endsequence
    sequence s_drd; dma_req_i && !dma_we_i; endsequence
    chk_cpu_rd_ans: assert property (s_crd |=> cpu_rvalid_o)
        else $error("cpu read unanswered");
    chk_dma_rd_ans: assert property (s_drd |=> dma_rvalid_o)
        else $error("dma read unanswered");
    chk_cpu_no_extra: assert property (cpu_we_i || !cpu_req_i
        |=> !cpu_rvalid_o) else $error("cpu spurious valid");
    chk_cpu_byte_low: assert property (s_crd ##0 cpu_byte_i
        |=> cpu_rdata_o[15:8] == 8'h00) else $error("cpu byte high");
    chk_dma_byte_low: assert property (s_drd ##0 dma_byte_i
        |=> dma_rdata_o[15:8] == 8'h00) else $error("dma byte high");
    chk_cpu_miss_zero: assert property (s_crd ##0
        (cpu_addr_i & WIN_MASK) != BASE |=> cpu_rdata_o == 16'h0000)
        else $error("cpu miss not zero");
    chk_dma_miss_zero: assert property (s_drd ##0
        (dma_addr_i & WIN_MASK) != BASE |=> dma_rdata_o == 16'h0000)
        else $error("dma miss not zero");
    chk_cpu_rd_hold: assert property (!cpu_rvalid_o
        |-> $stable(cpu_rdata_o)) else $error("cpu data moved");
    chk_dma_no_extra: assert property (dma_we_i || !dma_req_i
        |=> !dma_rvalid_o) else $error("dma spurious valid");
    chk_dma_rd_hold: assert property (!dma_rvalid_o
        |-> $stable(dma_rdata_o)) else $error("dma data moved");
endmodule

//--- verif/dma_ctl_model.sv
// Purpose: dma controller side of the ram
// Assumes: commands change just after clk_i rises
// Notes:   idle data lines never echo the last word
`timescale 1ns/1ps
module dma_ctl_model (
    // commands from the bench
    input  wire logic        go_i,
    input  wire logic        wr_i,
    input  wire logic        bt_i,
    input  wire logic [15:0] a_i,
    input  wire logic [15:0] d_i,
    // dma port of the ram
    output logic             req_o,
    output logic             we_o,
    output logic             byte_o,
    output logic [15:0]      addr_o,
    output logic [15:0]      data_o
);
    assign {req_o, we_o, byte_o, addr_o} = {go_i, wr_i, bt_i, a_i};
    assign data_o = (go_i && wr_i) ? d_i : ~d_i;
endmodule

//--- verif/dma_ram_tb_top.sv
// Purpose: self-checking bench for dma_ram
// Assumes: reads answer one cycle after being taken
// Notes:   a word-array reference predicts reads
`timescale 1ns/1ps
module dma_ram_tb_top;
    import dma_ram_pkg::*;
    localparam logic [15:0] BASE = BASE_DFLT;
    logic clk_i = 0, sys_rst_i = 1, cpu_req_i = 0, cpu_we_i = 0;
    logic cpu_byte_i = 0, go = 0, wr = 0, bt = 0, cpu_rvalid_o, dma_rvalid_o;
    logic dma_req_i, dma_we_i, dma_byte_i;
    logic [15:0] cpu_addr_i = 0, cpu_wdata_i = 0, a = 0, d = 0, ca, da;
    logic [15:0] cpu_rdata_o, dma_addr_i, dma_wdata_i, dma_rdata_o;
    logic [15:0] mem [1024] = '{default: 16'h0000}, cq [$], dq [$];
    logic [31:0] r, s;
    int err_total = 0, n_tests = 0;
    dma_ram #(.BASE(BASE)) uut (.*);
    dma_ctl_model dmac (.go_i(go), .wr_i(wr), .bt_i(bt), .a_i(a), .d_i(d),
        .req_o(dma_req_i), .we_o(dma_we_i), .byte_o(dma_byte_i),
        .addr_o(dma_addr_i), .data_o(dma_wdata_i));
    initial forever #25 clk_i = ~clk_i;
    initial begin #100us; err_total++; final_report; end
    function automatic logic [15:0] rd(logic [15:0] ad, logic b);
        logic [15:0] w;
        w = ((ad & WIN_MASK) == BASE) ? mem[ad[10:1]] : 16'h0000;
        return b ? {8'h00, ad[0] ? w[15:8] : w[7:0]} : w;
    endfunction
    task automatic wr_ref(logic [15:0] ad, logic b, logic [15:0] v);
        if ((ad & WIN_MASK) != BASE) return;
        if (!b) mem[ad[10:1]] = v;
        else if (ad[0]) mem[ad[10:1]][15:8] = v[7:0];
        else mem[ad[10:1]][7:0] = v[7:0];
    endtask
    task automatic step(logic cr, cw, cb, logic [15:0] xa, xd,
                        logic dr, dw, db, logic [15:0] ya, yd);
        @(posedge clk_i);
        if (cr && !cw) cq.push_back(rd(xa, cb));
        if (dr && !dw) dq.push_back(rd(ya, db));
        // cpu applied last so it wins a shared lane
        if (dr && dw) wr_ref(ya, db, yd);
        if (cr && cw) wr_ref(xa, cb, xd);
        {cpu_req_i, cpu_we_i, cpu_byte_i, cpu_addr_i, cpu_wdata_i} <=
            {cr, cw, cb, xa, xd};
        {go, wr, bt, a, d} <= {dr, dw, db, ya, yd};
    endtask
    task automatic cmp(logic [15:0] g, e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t read %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report;
        if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(negedge clk_i) begin
        if (cpu_rvalid_o === 1'b1) cmp(cpu_rdata_o, cq.pop_front());
        if (dma_rvalid_o === 1'b1) cmp(dma_rdata_o, dq.pop_front());
    end
    initial begin
        void'($urandom(32'h118d1b4e));
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 0;
        for (int i = 0; i < 4; i++)
            step(1, 0, i[0], BASE + 16'(i), 0, 1, 0, 1, ~16'(i), 0);
        repeat (400) begin
            r = $urandom;
            s = $urandom;
            ca = s[1:0] != 0 ? BASE + 16'(s[12:2]) : s[31:16];
            da = s[14:13] == 0 ? ca : BASE + 16'(s[25:15]);
            step(r[0], r[1], r[2], ca, r[31:16],
                 r[3], r[4], r[5], da, ~r[31:16]);
        end
        step(1, 1, 0, BASE + 16'h0400, 16'h5aa5, 0, 0, 0, 0, 0);
        step(1, 0, 0, BASE + 16'h0400, 0, 0, 0, 0, 0, 0);
        step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(posedge clk_i);
        // a reset in mid-run clears the whole array
        sys_rst_i <= 1;
        mem = '{default: 16'h0000};
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 0;
        step(1, 0, 0, BASE + 16'h0400, 0, 1, 0, 0, BASE + 16'h0400, 0);
        step(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(posedge clk_i);
        err_total += cq.size() + dq.size();
        final_report;
    end
endmodule
bind dma_ram dma_ram_monitor #(.BASE(BASE)) mon (.*);
